/* File: ssei_top.sv */
// serial eeprom slave: spi pins, command sequencer, array and status
// assumes all pins asynchronous; sck slower than clk/8
`timescale 1ns/1ps
`default_nettype none
// How it works
// - si sampled on sck rise, so updated on sck fall.
// - first bit is the first sck rise after select falls.
// - eight-bit instruction register; everything shifts msb first.
// - guard pin low with enable set blocks status writes.
// - a started programming cycle always finishes.
// - enable clear means the guard pin is ignored.
// - pause falling with sck high waits for the next sck fall.
// - paused: sck and si ignored, so released, sequence kept.
// - resume when pause rises with sck low, from the same point.
// - read is instruction plus 16 address bits, top three ignored.
// - read address increments per byte and wraps to zero.
// - latch sets only on select rise after complete set instruction.
// - write wraps inside its 32-byte page, overwriting earlier bytes.
// - programming starts only if select rises right after a byte.
// - array reads refused while programming; status reads still answered.
// - latch cleared on reset, clear command, status write, array write end.
// - codes 03 read, 02 write, 06 set latch.
// - codes 04 clear latch, 05 read status, 01 write status.
// - status layout: enable 7, protect 3:2, latch 1, busy 0.
// - latch commands ignored while busy; latch and busy not writable.
// - protect bits change only by status write or reset and are kept.
// - so released whenever select is high.
// - programming lasts the write time with busy set throughout.
module ssei_top
  import ssei_pkg::*;
#(
  parameter int WC_CYCLES = ssei_pkg::WC_CYCLES_DEF
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic hold_n,
  input wire logic guard_n,
  output logic so,
  output logic so_oe
);
  import ssei_pkg::*;

  typedef struct packed {
    ssei_state_t st;
    logic sck_q;
    logic paused;
    logic [15:0] sh;
    logic [4:0] cnt;
    logic [7:0] cmd;
    logic [ADDR_W-1:0] rd_addr;
    logic [PG_W-1:0] page;
    logic [PAGE_W-1:0] col;
    logic [PAGE_BYTES-1:0] mask;
    logic got;
    logic [7:0] sr;
    logic [2:0] ocnt;
    logic drv;
    logic so;
    logic so_oe;
    logic write_enable_latch;
    logic gpe;
    logic [1:0] bp;
    logic [2:0] nv;
    logic busy;
    logic is_sr;
    logic [5:0] walk;
    logic [TMR_W-1:0] tmr;
  } ssei_core_t;

  ssei_core_t q, d;
  logic cs_s, sck_s, si_s, hold_s, guard_s;
  logic rise, fall, wp_block;
  logic [15:0] shin;
  logic [7:0] byte_in, ob;
  logic pf_valid, pf_ready, fifo_clr;
  logic fo_valid, fo_pop;
  logic [7:0] fo_data, mem_rd;
  logic pb_we, mem_we;
  logic [PAGE_W-1:0] walk_idx;
  logic [7:0] mem [MEM_BYTES];
  logic [7:0] pbuf [PAGE_BYTES];

  // status byte as seen by a status read
  // status byte layout
  function automatic logic [7:0] status_byte(input ssei_core_t s);
    logic [7:0] b;
    b = 8'h00;
    b[SR_GPE] = s.gpe;
    b[SR_BPH] = s.bp[1];
    b[SR_BPL] = s.bp[0];
    b[SR_LATCH] = s.write_enable_latch;
    b[SR_PIP] = s.busy;
    return b;
  endfunction

  // every pin passes two flops before any logic sees it
  ssei_sync #(
    .W(5),
    .RST_VAL(5'h1B)
  ) u_sync (
    .clk(clk),
    .reset(reset),
    .d({cs_n, hold_n, sck, guard_n, si}),
    .q({cs_s, hold_s, sck_s, guard_s, si_s})
  );

  // read prefetch buffer; the shifter stalls it by not popping
  ssei_fifo2 #(
    .W(8)
  ) u_fifo (
    .clk(clk),
    .reset(reset),
    .clear(fifo_clr),
    .in_valid(pf_valid),
    .in_ready(pf_ready),
    .in_data(mem_rd),
    .out_valid(fo_valid),
    .out_ready(fo_pop),
    .out_data(fo_data)
  );

  // sck edges from the synchronised level and its delayed copy
  // edge detect
  assign rise = sck_s & ~q.sck_q;
  assign fall = ~sck_s & q.sck_q;
  assign shin = {q.sh[14:0], si_s};
  assign byte_in = shin[7:0];
  assign wp_block = q.gpe & ~guard_s;
  assign pf_valid = (q.st == ST_RDATA) & ~q.busy;
  assign mem_rd = mem[q.rd_addr];
  assign walk_idx = q.walk[PAGE_W-1:0];
  assign mem_we = q.busy & ~q.is_sr & (q.walk != WALK_END) & q.mask[walk_idx];
  assign pb_we = ~cs_s & ~q.paused & rise & (q.st == ST_WDATA) & (q.cnt[2:0] == BYTE_LAST);

  // sequencer: select, pause, sck edges and the programming timer
  always_comb begin
    d = q;
    fifo_clr = 1'b0;
    fo_pop = 1'b0;
    ob = 8'hFF;
    d.sck_q = sck_s;
    if (pf_valid & pf_ready) begin
      d.rd_addr = q.rd_addr + 1'b1;
    end
    // programming timer; walk copies the page into the array first
    // busy for whole cycle
    if (q.busy) begin
      if (q.walk != WALK_END) begin
        d.walk = q.walk + 1'b1;
      end
      if (q.tmr == '0) begin
        d.busy = 1'b0;
        d.write_enable_latch = 1'b0;
        if (q.is_sr) begin
          d.gpe = q.nv[2];
          d.bp = q.nv[1:0];
        end
      end else begin
        d.tmr = q.tmr - 1'b1;
      end
    end
    if (cs_s) begin
      // end of frame: act only on a frame that stopped cleanly
      case (q.st)
        ST_WAITCS: begin
          if (q.cmd == CMD_SET_LATCH) begin
            d.write_enable_latch = 1'b1;
          end
          if (q.cmd == CMD_CLEAR_LATCH) begin
            d.write_enable_latch = 1'b0;
          end
          if (q.cmd == CMD_WRITE_STATUS && !wp_block && !q.busy) begin
            d.busy = 1'b1;
            d.is_sr = 1'b1;
            d.walk = WALK_END;
            d.tmr = TMR_W'(WC_CYCLES - 1);
          end
        end
        ST_WDATA: begin
          // start only after a whole byte
          if (q.cnt == '0 && q.got && !q.busy) begin
            d.busy = 1'b1;
            d.is_sr = 1'b0;
            d.walk = '0;
            d.tmr = TMR_W'(WC_CYCLES - 1);
          end
        end
        default: begin
        end
      endcase
      d.st = ST_IDLE;
      d.paused = 1'b0;
      d.drv = 1'b0;
      d.cnt = '0;
      d.ocnt = '0;
    end else if (q.st == ST_IDLE) begin
      d.st = ST_CMD;
      d.cnt = '0;
    end else if (q.paused) begin
      if (hold_s && !sck_s) begin
        d.paused = 1'b0;
      end
    end else begin
      if (!hold_s && !sck_s) begin
        d.paused = 1'b1;
      end
      if (rise) begin
        d.sh = shin;
        d.cnt = q.cnt + 1'b1;
        case (q.st)
          ST_CMD: begin
            if (q.cnt == CMD_LAST) begin
              d.cmd = byte_in;
              d.cnt = '0;
              d.st = ST_IGNORE;
              if (!q.busy || byte_in == CMD_READ_STATUS) begin
                case (byte_in)
                  CMD_READ: begin
                    d.st = ST_ADDR;
                  end
                  CMD_WRITE: begin
                    d.st = q.write_enable_latch ? ST_ADDR : ST_IGNORE;
                  end
                  CMD_SET_LATCH: begin
                    d.st = ST_WAITCS;
                  end
                  CMD_CLEAR_LATCH: begin
                    d.st = ST_WAITCS;
                  end
                  CMD_READ_STATUS: begin
                    d.st = ST_SRD;
                  end
                  CMD_WRITE_STATUS: begin
                    d.st = q.write_enable_latch ? ST_SWR : ST_IGNORE;
                  end
                  default: begin
                    d.st = ST_IGNORE;
                  end
                endcase
              end
            end
          end
          ST_ADDR: begin
            if (q.cnt == ADDR_LAST) begin
              d.cnt = '0;
              if (q.cmd == CMD_READ) begin
                d.st = ST_RDATA;
                d.rd_addr = shin[ADDR_W-1:0];
                fifo_clr = 1'b1;
              end else begin
                d.st = ST_WDATA;
                d.page = shin[ADDR_W-1:PAGE_W];
                d.col = shin[PAGE_W-1:0];
                d.mask = '0;
                d.got = 1'b0;
              end
            end
          end
          ST_WDATA: begin
            if (q.cnt[2:0] == BYTE_LAST) begin
              d.cnt = '0;
              d.col = q.col + 1'b1;
              d.mask[q.col] = 1'b1;
              d.got = 1'b1;
            end
          end
          ST_SWR: begin
            // latch and busy bits not taken
            if (q.cnt == CMD_LAST) begin
              d.nv = {byte_in[SR_GPE], byte_in[SR_BPH], byte_in[SR_BPL]};
              d.st = ST_WAITCS;
            end
          end
          ST_WAITCS: begin
            // extra clocks spoil the command
            d.st = ST_IGNORE;
          end
          default: begin
            d.cnt = q.cnt;
          end
        endcase
      end
      // output shifter, new bit after each sck fall
      // so changes on fall
      if (fall && (q.st == ST_RDATA || q.st == ST_SRD)) begin
        d.drv = 1'b1;
        if (q.ocnt == '0) begin
          if (q.st == ST_SRD) begin
            ob = status_byte(q);
          end else begin
            ob = fo_valid ? fo_data : 8'hFF;
            fo_pop = fo_valid;
          end
          d.so = ob[7];
          d.sr = {ob[6:0], 1'b0};
          d.ocnt = BYTE_LAST;
        end else begin
          d.so = q.sr[7];
          d.sr = {q.sr[6:0], 1'b0};
          d.ocnt = q.ocnt - 1'b1;
        end
      end
    end
    d.so_oe = d.drv & ~d.paused & ~cs_s;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      q <= '0;
      q.st <= ST_IDLE;
      q.sck_q <= 1'b0;
      q.gpe <= GPE_RST;
      q.bp <= BP_RST;
      q.walk <= WALK_END;
    end else begin
      q <= d;
    end
  end

  // page buffer and array have no reset: they model storage cells
  always_ff @(posedge clk) begin
    if (pb_we) begin
      pbuf[q.col] <= byte_in;
    end
    // only loaded bytes reach the array
    if (mem_we) begin
      mem[{q.page, walk_idx}] <= pbuf[walk_idx];
    end
  end

  assign so = q.so;
  assign so_oe = q.so_oe;
endmodule
`default_nettype wire

/* File: ssei_pkg.sv */
// constants, state codes and field layout of the serial eeprom slave
// assumes a 250 MHz core clock sampling all serial pins
package ssei_pkg;
  // array geometry
  localparam int ADDR_W = 13;
  localparam int PAGE_W = 5;
  localparam int PAGE_BYTES = 32;
  localparam int MEM_BYTES = 8192;
  localparam int PG_W = ADDR_W - PAGE_W;
  localparam logic [5:0] WALK_END = 6'h20;
  // instruction codes
  localparam logic [7:0] CMD_WRITE_STATUS = 8'h01;
  localparam logic [7:0] CMD_WRITE = 8'h02;
  localparam logic [7:0] CMD_READ = 8'h03;
  localparam logic [7:0] CMD_CLEAR_LATCH = 8'h04;
  localparam logic [7:0] CMD_READ_STATUS = 8'h05;
  localparam logic [7:0] CMD_SET_LATCH = 8'h06;
  // bit counters: last bit of instruction, address and byte
  localparam logic [4:0] CMD_LAST = 5'h07;
  localparam logic [4:0] ADDR_LAST = 5'h0F;
  localparam logic [2:0] BYTE_LAST = 3'h7;
  // status register field positions
  localparam int SR_GPE = 7;
  localparam int SR_BPH = 3;
  localparam int SR_BPL = 2;
  localparam int SR_LATCH = 1;
  localparam int SR_PIP = 0;
  // reset values of the non-volatile bits (blank part)
  localparam logic GPE_RST = 1'b0;
  localparam logic [1:0] BP_RST = 2'h0;
  // programming time, longest figure rounded down to cycles
  localparam int WC_TIME_MS = 5;
  localparam int CLK_PERIOD_NS = 4;
  localparam int WC_CYCLES_DEF = WC_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int TMR_W = 21;
  // sequencer states, one-hot
  typedef enum logic [8:0] {
    ST_IDLE = 9'h001,
    ST_CMD = 9'h002,
    ST_ADDR = 9'h004,
    ST_RDATA = 9'h008,
    ST_WDATA = 9'h010,
    ST_SRD = 9'h020,
    ST_SWR = 9'h040,
    ST_WAITCS = 9'h080,
    ST_IGNORE = 9'h100
  } ssei_state_t;
endpackage

/* File: ssei_sync.sv */
// two-flop synchroniser for a group of pin levels
// assumes pins are asynchronous to clk; second flop is the only output
`timescale 1ns/1ps
`default_nettype none
module ssei_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } ssei_sync_t;
  ssei_sync_t r_q, r_d;
  // first stage feeds only the second
  always_comb begin
    r_d.s1 = d;
    r_d.s2 = r_q.s1;
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      r_q <= {RST_VAL, RST_VAL};
    end else begin
      r_q <= r_d;
    end
  end
  assign q = r_q.s2;
endmodule
`default_nettype wire

/* File: ssei_fifo2.sv */
// two-entry buffer with valid/ready on both sides and a flush input
// assumes clear is a one-cycle pulse from logic on clk
`timescale 1ns/1ps
`default_nettype none
module ssei_fifo2 #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic clear,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  typedef struct packed {
    logic [1:0][W-1:0] mem;
    logic wp;
    logic rp;
    logic [1:0] cnt;
  } ssei_fifo_t;
  ssei_fifo_t f_q, f_d;
  logic push, pop;
  // full and empty come straight from the count
  assign in_ready = (f_q.cnt != 2'h2);
  assign out_valid = (f_q.cnt != 2'h0);
  assign out_data = f_q.mem[f_q.rp];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  always_comb begin
    f_d = f_q;
    if (clear) begin
      f_d.wp = 1'b0;
      f_d.rp = 1'b0;
      f_d.cnt = 2'h0;
    end else begin
      if (push) begin
        f_d.mem[f_q.wp] = in_data;
        f_d.wp = ~f_q.wp;
      end
      if (pop) begin
        f_d.rp = ~f_q.rp;
      end
      f_d.cnt = f_q.cnt + {1'b0, push} - {1'b0, pop};
    end
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      f_q <= '0;
    end else begin
      f_q <= f_d;
    end
  end
endmodule
`default_nettype wire

/* File: ssei_top_chk.sv */
// pin-level checker for the serial eeprom slave
// assumes it is bound to ssei_top and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module ssei_top_chk (
  input wire logic clk,
  input wire logic reset,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic hold_n,
  input wire logic guard_n,
  input wire logic so,
  input wire logic so_oe
);
  logic sck_q;
  logic [7:0] rise_cnt;
  // sck rises in the current frame, saturating so long reads never wrap
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sck_q <= 1'b0;
      rise_cnt <= 8'h00;
    end else begin
      sck_q <= sck;
      if (cs_n) begin
        rise_cnt <= 8'h00;
      end else if (sck && !sck_q && rise_cnt != 8'hFF) begin
        rise_cnt <= rise_cnt + 8'h01;
      end
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  property p_cs_release;
    $rose(cs_n) |-> ##[1:5] !so_oe;
  endproperty
  a_cs_release: assert property (p_cs_release) else $error("so driven after deselect");
  property p_idle;
    cs_n [*6] |-> !so_oe;
  endproperty
  a_idle: assert property (p_idle) else $error("so driven while deselected");
  property p_pause_quiet;
    (!hold_n && !sck) [*6] |-> !so_oe;
  endproperty
  a_pause_quiet: assert property (p_pause_quiet) else $error("so driven while paused");
  property p_so_after_fall;
    so_oe && $past(so_oe) && $changed(so) |-> !sck && !$past(sck);
  endproperty
  a_so_after_fall: assert property (p_so_after_fall) else $error("so moved with sck high");
  property p_drive_sel;
    $rose(so_oe) |-> !cs_n && !sck;
  endproperty
  a_drive_sel: assert property (p_drive_sel) else $error("so enabled out of frame");
  property p_drive_resume;
    $rose(so_oe) |-> hold_n && $past(hold_n, 2);
  endproperty
  a_drive_resume: assert property (p_drive_resume) else $error("so enabled in pause");
  property p_after_cmd;
    $rose(so_oe) |-> rise_cnt >= 8'h08;
  endproperty
  a_after_cmd: assert property (p_after_cmd) else $error("so enabled before opcode");
  property p_keep_driving;
    $fell(so_oe) |-> $past(cs_n, 2) || !$past(hold_n, 2);
  endproperty
  a_keep_driving: assert property (p_keep_driving) else $error("read output dropped");
endmodule
bind ssei_top ssei_top_chk u_ssei_top_chk (.clk(clk), .reset(reset), .cs_n(cs_n), .sck(sck),
  .si(si), .hold_n(hold_n), .guard_n(guard_n), .so(so), .so_oe(so_oe));
`default_nettype wire

/* File: ssei_master.sv */
// spi master model facing the serial eeprom slave, mode 0
// assumes the bench calls its tasks; pins change only at clk falls
`timescale 1ns/1ps
`default_nettype none
module ssei_master (
  input wire logic clk,
  input wire logic so,
  input wire logic so_oe,
  output logic cs_n,
  output logic sck,
  output logic si,
  output logic hold_n
);
  logic oe_seen;
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    hold_n = 1'b1;
    oe_seen = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask
  // select stays low for the frame
  task automatic start();
    wt(1);
    cs_n = 1'b0;
    oe_seen = 1'b0;
    wt(8);
  endtask
  // deselect only after a whole last bit; released si flips
  task automatic stop();
    wt(8);
    cs_n = 1'b1;
    si = ~si;
    wt(8);
  endtask
  // msb first, si set while sck low, so taken at the rise
  task automatic xb(input logic [7:0] tx, input int nb, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = nb - 1; i >= 0; i--) begin
      si = tx[i];
      wt(8);
      sck = 1'b1;
      // a released line reads as the inverse of the last bit, so a missing enable shows
      rx = {rx[6:0], so_oe ? so : ~so};
      oe_seen = oe_seen | so_oe;
      wt(8);
      sck = 1'b0;
    end
  endtask
  // pause and resume with sck low; sck pulse meanwhile is noise
  task automatic pause(output logic oe);
    wt(8);
    hold_n = 1'b0;
    wt(8);
    sck = 1'b1;
    wt(8);
    sck = 1'b0;
    wt(8);
    oe = so_oe;
    hold_n = 1'b1;
    wt(8);
  endtask
  // pause asked with sck high; the bit at that rise still counts
  task automatic pause_hi(output logic oe, output logic bt);
    wt(8);
    sck = 1'b1;
    bt = so_oe ? so : ~so;
    hold_n = 1'b0;
    wt(8);
    sck = 1'b0;
    wt(8);
    oe = so_oe;
    hold_n = 1'b1;
    wt(8);
  endtask
endmodule
`default_nettype wire

/* File: ssei_top_tb.sv */
// self-checking bench for the serial eeprom slave
// assumes the master model drives the link; write time shortened
`timescale 1ns/1ps
`default_nettype none
module ssei_top_tb;
  import ssei_pkg::*;
  localparam int WC = 2000;
  logic clk, reset, cs_n, sck, si, hold_n, guard_n, so, so_oe, oe;
  logic [7:0] sr;
  logic [31:0] v;
  int n_fail;
  int tests_run;
  ssei_top #(.WC_CYCLES(WC)) u_ssei_top (.clk(clk), .reset(reset), .cs_n(cs_n), .sck(sck),
    .si(si), .hold_n(hold_n), .guard_n(guard_n), .so(so), .so_oe(so_oe));
  ssei_master u_ssei_master (.clk(clk), .so(so), .so_oe(so_oe), .cs_n(cs_n), .sck(sck),
    .si(si), .hold_n(hold_n));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic sx(input logic [7:0] b);
    logic [7:0] d;
    u_ssei_master.xb(b, 8, d);
  endtask
  task automatic cmd(input logic [7:0] op);
    u_ssei_master.start();
    sx(op);
    u_ssei_master.stop();
  endtask
  task automatic read_status();
    u_ssei_master.start();
    sx(CMD_READ_STATUS);
    u_ssei_master.xb(8'hFF, 8, sr);
    u_ssei_master.stop();
  endtask
  // poll under a bound; the write time is WC clocks, about seven frames
  task automatic wait_idle();
    int k = 0;
    read_status();
    while (sr[0] !== 1'b0 && k < 20) begin
      read_status();
      k++;
    end
    chk("busy clears", 32'h0, {31'h0, sr[0]});
  endtask
  task automatic wframe(input logic [15:0] a, input int n, input logic [7:0] b, input int nb);
    logic [7:0] d;
    u_ssei_master.start();
    sx(CMD_WRITE);
    sx(a[15:8]);
    sx(a[7:0]);
    for (int i = 0; i < n; i++) begin
      u_ssei_master.xb(b + 8'(i), (i == n - 1) ? nb : 8, d);
    end
    u_ssei_master.stop();
  endtask
  task automatic wr(input logic [15:0] a, input int n, input logic [7:0] b);
    cmd(CMD_SET_LATCH);
    wframe(a, n, b, 8);
    read_status();
    chk("busy and latch", 32'h03, {24'h0, sr});
    wait_idle();
    chk("latch after write", 32'h00, {24'h0, sr});
  endtask
  task automatic rd(input logic [15:0] a, input int n);
    logic [7:0] d;
    v = '0;
    u_ssei_master.start();
    sx(CMD_READ);
    sx(a[15:8]);
    sx(a[7:0]);
    for (int i = 0; i < n; i++) begin
      u_ssei_master.xb(8'hFF, 8, d);
      v = {v[23:0], d};
    end
    u_ssei_master.stop();
  endtask
  task automatic sw(input logic [7:0] b);
    cmd(CMD_SET_LATCH);
    u_ssei_master.start();
    sx(CMD_WRITE_STATUS);
    sx(b);
    u_ssei_master.stop();
  endtask
  task automatic t_latch();
    read_status();
    chk("reset status", 32'h00, {24'h0, sr});
    cmd(CMD_SET_LATCH);
    read_status();
    chk("latch set", 32'h02, {24'h0, sr});
    cmd(CMD_CLEAR_LATCH);
    read_status();
    chk("latch clear", 32'h00, {24'h0, sr});
    u_ssei_master.start();
    sx(CMD_SET_LATCH);
    sx(CMD_WRITE);
    sx(8'h00);
    sx(8'h10);
    sx(8'h55);
    u_ssei_master.stop();
    read_status();
    chk("latch in same frame", 32'h00, {24'h0, sr});
  endtask
  task automatic t_write();
    wr(16'h0000, 1, 8'h3C);
    wr(16'hFFFE, 3, 8'hA1);
    rd(16'hFFFE, 3);
    chk("read across top", 32'h00A1A23C, v);
    rd(16'h1FE0, 1);
    chk("page wrap", 32'h000000A3, v);
  endtask
  task automatic t_refuse();
    cmd(CMD_SET_LATCH);
    wframe(16'h0000, 1, 8'h99, 8);
    rd(16'h0000, 1);
    chk("array read in cycle", 32'h0, {31'h0, u_ssei_master.oe_seen});
    read_status();
    chk("status in cycle", 32'h03, {24'h0, sr});
    wait_idle();
    rd(16'h0000, 1);
    chk("written byte", 32'h99, v);
    cmd(CMD_SET_LATCH);
    wframe(16'h0000, 1, 8'h55, 4);
    read_status();
    chk("aborted write", 32'h02, {24'h0, sr});
    cmd(CMD_CLEAR_LATCH);
    wframe(16'h0000, 1, 8'h66, 8);
    read_status();
    chk("write without latch", 32'h00, {24'h0, sr});
    rd(16'h0000, 1);
    chk("array kept", 32'h99, v);
  endtask
  task automatic t_status();
    guard_n = 1'b0;
    sw(8'h8F);
    wait_idle();
    chk("guard ignored", 32'h8C, {24'h0, sr});
    sw(8'h00);
    read_status();
    chk("guard blocks", 32'h8C, {24'h0, sr & 8'h8D});
    guard_n = 1'b1;
    sw(8'h00);
    guard_n = 1'b0;
    wait_idle();
    chk("started cycle ends", 32'h00, {24'h0, sr});
    guard_n = 1'b1;
  endtask
  task automatic t_hold();
    logic [7:0] a;
    logic [7:0] b;
    logic bt;
    u_ssei_master.start();
    sx(CMD_READ);
    sx(8'h00);
    sx(8'h00);
    u_ssei_master.xb(8'hFF, 4, a);
    u_ssei_master.pause(oe);
    chk("released in pause", 32'h0, {31'h0, oe});
    u_ssei_master.xb(8'hFF, 4, b);
    u_ssei_master.stop();
    chk("resumed byte", 32'h99, {24'h0, a[3:0], b[3:0]});
    // second frame: pause asked while sck is high, taken at the following fall
    u_ssei_master.start();
    sx(CMD_READ);
    sx(8'h1F);
    sx(8'hFE);
    u_ssei_master.xb(8'hFF, 3, a);
    u_ssei_master.pause_hi(oe, bt);
    chk("released after late pause", 32'h0, {31'h0, oe});
    u_ssei_master.xb(8'hFF, 4, b);
    u_ssei_master.stop();
    chk("byte across late pause", 32'hA1, {24'h0, a[2:0], bt, b[3:0]});
  endtask
  initial begin
    reset = 1'b1;
    guard_n = 1'b1;
    n_fail = 0;
    tests_run = 0;
    repeat (12) @(negedge clk);
    reset = 1'b0;
    repeat (8) @(negedge clk);
    t_latch();
    t_write();
    t_refuse();
    t_status();
    t_hold();
    tally_and_finish();
  end
  // the run needs about 23000 clocks
  initial begin
    repeat (90000) @(posedge clk);
    n_fail++;
    $display("Error watchdog expected done seen hang");
    tally_and_finish();
  end
endmodule
`default_nettype wire
